// >>> lcd_panel_model.sv
// panel side monitor: times line, frame, bias and shift edges
// assumes config inputs are held steady while on is high
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model #(
   parameter int TS = 2
) (
   // clock and config
   input  wire logic                     clk,
   input  wire logic                     on,
   input  wire logic [1:0]               md,
   input  wire logic [6:0]               hd,
   input  wire logic [4:0]               hb,
   input  wire logic [9:0]               vd,
   input  wire logic [5:0]               vb,
   // panel pins
   input  wire panel_timing_pkg::panel_t pnl,
   // tallies
   output var  int                       n_bad,
   output var  int                       n_seen
);
   import panel_timing_pkg::*;
   panel_t p = '0;
   int cyc, t_lr, t_lf, t_sr, t_sf, t_fr, falls, lidx, half, wid, tot;
   logic run = 1'b0;
   logic inl = 1'b0;
   // ************
   // edge timing
   // ************
   task automatic chk(input int got, input int exp);
      n_seen++;
      if (got != exp) begin
         n_bad++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   always @(posedge clk) begin
      half = (md == 2'h2) ? TS / 2 : (md == 2'h1) ? 4 * TS : 2 * TS;
      wid = (hd + 1) * 8 * TS;
      tot = vd + vb + 1;
      cyc++;
      if (!on) begin
         run = 1'b0;
         inl = 1'b0;
         lidx = tot - 1;
      end else begin
         if (pnl.line_pulse && !p.line_pulse) begin
            if (run) begin
               chk(cyc - t_lr, wid + (hb + 4) * 8 * TS);
               chk(falls, (lidx <= vd) ? wid / (2 * half) : 0);
               if (falls > 0) chk(cyc - t_sf, hb * 8 * TS + half);
            end
            run = 1'b1;
            inl = 1'b0;
            falls = 0;
            t_lr = cyc;
            lidx = (lidx + 1) % tot;
         end
         if (!pnl.line_pulse && p.line_pulse) begin
            chk(cyc - t_lr, 9 * TS);
            t_lf = cyc;
            if (pnl.frame_pulse) chk(cyc - t_fr, wid + (hb + 4) * 8 * TS - 9 * TS);
         end
         if (pnl.frame_pulse && !p.frame_pulse) begin
            t_fr = cyc;
            chk(lidx, tot - 1);
         end
         if (!pnl.frame_pulse && p.frame_pulse) chk(cyc - t_lf, 9 * TS);
         if (pnl.ac_bias_toggle != p.ac_bias_toggle) chk(cyc - t_lr, TS);
         if (pnl.shift && !p.shift) begin
            chk(cyc - (inl ? t_sf : t_lf), inl ? half : 23 * TS);
            inl = 1'b1;
            t_sr = cyc;
         end
         if (!pnl.shift && p.shift) begin
            chk(cyc - t_sr, half);
            falls++;
            t_sf = cyc;
         end
      end
      p = pnl;
   end
endmodule
`default_nettype wire

// >>> panel_timing_defines.svh
// register offsets, field positions, reset values and timing counts of the panel timing generator
// assumes one system clock; timing counts are in pixel clock periods
`ifndef PANEL_TIMING_DEFINES_SVH
`define PANEL_TIMING_DEFINES_SVH
`define REG_CTRL        8'h00
`define REG_HDISP       8'h04
`define REG_HBLANK      8'h08
`define REG_VDISP       8'h0c
`define REG_VBLANK      8'h10
`define REG_STATUS      8'h14
`define CTRL_EN_BIT     0
`define CTRL_MODE_LSB   1
`define STAT_VBLANK_BIT 16
`define STAT_ACB_BIT    17
`define RST_HDISP       7'h27
`define RST_HBLANK      5'h00
`define RST_VDISP       10'h0ef
`define RST_VBLANK      6'h00
`define LP_WIDTH_TS     12'h009
`define SHIFT_DELAY_TS  12'h017
`define DISP_START_TS   (`LP_WIDTH_TS + `SHIFT_DELAY_TS)
`define FP_EDGE_TS      (`LP_WIDTH_TS + `LP_WIDTH_TS)
`define MOD_DELAY_TS    12'h001
`define HBLANK_OFFSET   12'h004
`define COLUMN_TS       12'h008
`endif

// >>> panel_timing_pkg.sv
// types shared by the panel timing generator
// assumes the constants header for widths of nothing; types only
package panel_timing_pkg;
   typedef enum logic [1:0] {
      MODE_MONO4    = 2'h0,
      MODE_MONO8    = 2'h1,
      MODE_COLOR4   = 2'h2,
      MODE_COLOR8F1 = 2'h3
   } mode_t;
   typedef enum logic [3:0] {
      H_SYNC   = 4'h1,
      H_PORCH  = 4'h2,
      H_ACTIVE = 4'h4,
      H_BLANK  = 4'h8
   } hphase_t;
   typedef struct packed {
      logic       frame_pulse;
      logic       line_pulse;
      logic       shift;
      logic       shift2;
      logic       ac_bias_toggle;
      logic [7:0] panel_pixel_data;
   } panel_t;
   typedef struct packed {
      logic        en;
      mode_t       mode;
      logic [6:0]  hdisp;
      logic [4:0]  hblank;
      logic [9:0]  vdisp;
      logic [5:0]  vblank;
      logic [7:0]  div;
      logic        half;
      logic [11:0] hc;
      logic [10:0] line;
      panel_t      pnl;
      logic [31:0] prdata;
   } state_t;
endpackage

// >>> passive_lcd_panel_timing_gen.sv
// passive lcd panel timing generator with an apb register slave
// assumes pixel data source on SYS_CLK; config is stable while enabled
`timescale 1ns/1ps
`default_nettype none
`include "panel_timing_defines.svh"
module passive_lcd_panel_timing_gen #(
   parameter int unsigned DIV = 2
) (
   // system
   input  wire logic                      SYS_CLK,
   input  wire logic                      RSTN,
   // apb slave
   input  wire logic                      PSEL,
   input  wire logic                      PENABLE,
   input  wire logic                      PWRITE,
   input  wire logic [7:0]                PADDR,
   input  wire logic [31:0]               PWDATA,
   output logic      [31:0]               PRDATA,
   output logic                           PREADY,
   output logic                           PSLVERR,
   // pixel source
   input  wire logic [7:0]                PIX_DATA,
   output logic                           PIX_REQ,
   // panel
   output panel_timing_pkg::panel_t       PANEL
);
   import panel_timing_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   localparam int TS_CYC = 2 * DIV;

   state_t      s;
   state_t      n;
   hphase_t     ph;
   logic [11:0] hd_ts;
   logic [11:0] ht;
   logic [10:0] vt;
   logic [12:0] p;
   logic [12:0] pend;
   logic        tick;
   logic        first;
   logic        disp;
   logic        sh;
   logic        sh2;
   logic        ld;

   function automatic logic [11:0] hdisp_ts(input logic [6:0] hd);
      hdisp_ts = ({5'h00, hd} + 12'h001) * `COLUMN_TS;
   endfunction

   function automatic logic [11:0] htotal(input logic [6:0] hd, input logic [4:0] hb);
      htotal = hdisp_ts(hd) + ({7'h00, hb} + `HBLANK_OFFSET) * `COLUMN_TS;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `REG_CTRL) || (a == `REG_HDISP) || (a == `REG_HBLANK) ||
               (a == `REG_VDISP) || (a == `REG_VBLANK) || (a == `REG_STATUS);
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      n     = s;
      hd_ts = hdisp_ts(s.hdisp);
      ht    = htotal(s.hdisp, s.hblank);
      vt    = {1'b0, s.vdisp} + 11'h001 + {5'h00, s.vblank};
      tick  = (s.div == 8'(DIV - 1));
      first = (s.div == 8'h00);
      disp  = (s.line <= {1'b0, s.vdisp});
      p     = {s.hc - `DISP_START_TS, s.half};
      pend  = {hd_ts, 1'b0};
      sh    = 1'b0;
      sh2   = 1'b0;
      ld    = 1'b0;
      // shift window opens 23 Ts after line fall
      if (s.hc < `LP_WIDTH_TS) begin
         ph = H_SYNC;
      end else if (s.hc < `DISP_START_TS) begin
         ph = H_PORCH;
      end else if (s.hc < `DISP_START_TS + hd_ts) begin
         ph = H_ACTIVE;
      end else begin
         ph = H_BLANK;
      end
      unique case (ph)
         H_SYNC, H_PORCH, H_BLANK: begin
            sh = 1'b0;
         end
         H_ACTIVE: begin
            if (disp) begin
               unique case (s.mode)
                  MODE_MONO4: begin
                     sh = ~p[2];
                     ld = first && (p[2:0] == 3'h0);
                  end
                  MODE_MONO8: begin
                     sh = ~p[3];
                     ld = first && (p[3:0] == 4'h0);
                  end
                  MODE_COLOR4: begin
                     sh = ~p[0];
                     ld = first && !p[0];
                  end
                  MODE_COLOR8F1: begin
                     // second clock dropped in the last 2 Ts
                     sh  = ~p[2];
                     sh2 = p[2] && (p < pend - 13'h0004);
                     ld  = first && (p[1:0] == 2'h2) && (p < pend - 13'h0004);
                  end
               endcase
            end
         end
      endcase

      if (!s.en) begin
         n.div  = 8'h00;
         n.half = 1'b0;
         n.hc   = 12'h000;
         n.line = 11'h000;
         n.pnl  = '0;
      end else begin
         n.div = tick ? 8'h00 : s.div + 8'h01;
         if (tick) begin
            n.half = ~s.half;
            if (s.half) begin
               if (s.hc >= ht - 12'h001) begin
                  n.hc   = 12'h000;
                  n.line = (s.line >= vt - 11'h001) ? 11'h000 : s.line + 11'h001;
               end else begin
                  n.hc = s.hc + 12'h001;
               end
            end
         end
         n.pnl.line_pulse = (ph == H_SYNC);
         n.pnl.shift      = sh;
         n.pnl.shift2     = sh2;
         // frame pulse edges 9 Ts after line fall
         if (first && !s.half && (s.hc == `FP_EDGE_TS)) begin
            n.pnl.frame_pulse = (s.line == vt - 11'h001);
         end
         // ac bias toggles once per frame
         if (first && !s.half && (s.hc == `MOD_DELAY_TS) && (s.line == 11'h000)) begin
            n.pnl.ac_bias_toggle = ~s.pnl.ac_bias_toggle;
         end
         // data changes at a shift rise, or in MODE_COLOR8F1 midway through a shift or shift2 high phase
         if (ld) begin
            if ((s.mode == MODE_MONO8) || (s.mode == MODE_COLOR8F1)) begin
               n.pnl.panel_pixel_data = PIX_DATA;
            end else begin
               n.pnl.panel_pixel_data = {PIX_DATA[7:4], 4'h0};
            end
         end
      end

      // read data is captured in the setup phase, so access needs no wait
      if (PSEL && !PENABLE) begin
         case (PADDR)
            `REG_CTRL:   n.prdata = {29'h0, s.mode, s.en};
            `REG_HDISP:  n.prdata = {25'h0, s.hdisp};
            `REG_HBLANK: n.prdata = {27'h0, s.hblank};
            `REG_VDISP:  n.prdata = {22'h0, s.vdisp};
            `REG_VBLANK: n.prdata = {26'h0, s.vblank};
            `REG_STATUS: n.prdata = {14'h0, s.pnl.ac_bias_toggle, !disp, 5'h00, s.line};
            default:     n.prdata = 32'h0;
         endcase
      end
      if (PSEL && PENABLE && PWRITE) begin
         case (PADDR)
            `REG_CTRL: begin
               n.en   = PWDATA[`CTRL_EN_BIT];
               n.mode = mode_t'(PWDATA[`CTRL_MODE_LSB +: 2]);
            end
            `REG_HDISP:  n.hdisp  = PWDATA[6:0];
            `REG_HBLANK: n.hblank = PWDATA[4:0];
            `REG_VDISP:  n.vdisp  = PWDATA[9:0];
            `REG_VBLANK: n.vblank = PWDATA[5:0];
            default:     n.en     = s.en;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         s <= '{en: 1'b0, mode: MODE_MONO4, hdisp: `RST_HDISP, hblank: `RST_HBLANK,
                vdisp: `RST_VDISP, vblank: `RST_VBLANK, default: '0};
      end else begin
         s <= n;
      end
   end

   assign PRDATA  = s.prdata;
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !mapped(PADDR);
   assign PIX_REQ = ld;
   assign PANEL   = s.pnl;

   // ****************************************
   // assertions
   // ****************************************
   logic [15:0] lp_hi;
   logic [15:0] lp_lo;
   logic [15:0] sh_hi;
   logic [31:0] per;
   logic        per_ok;

   function automatic logic [15:0] half_cyc(input mode_t m);
      unique case (m)
         MODE_MONO4:    half_cyc = 16'(2 * TS_CYC);
         MODE_MONO8:    half_cyc = 16'(4 * TS_CYC);
         MODE_COLOR4:   half_cyc = 16'(DIV);
         MODE_COLOR8F1: half_cyc = 16'(2 * TS_CYC);
      endcase
   endfunction

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         lp_hi  <= 16'h0000;
         lp_lo  <= 16'h0000;
         sh_hi  <= 16'h0000;
         per    <= 32'h0;
         per_ok <= 1'b0;
      end else begin
         lp_hi  <= PANEL.line_pulse ? lp_hi + 16'h0001 : 16'h0000;
         lp_lo  <= PANEL.line_pulse ? 16'h0000 : lp_lo + 16'h0001;
         sh_hi  <= PANEL.shift ? sh_hi + 16'h0001 : 16'h0000;
         per    <= (PANEL.line_pulse && lp_hi == 16'h0000) ? 32'h1 : per + 32'h1;
         per_ok <= s.en && (per_ok || (PANEL.line_pulse && lp_hi == 16'h0000));
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);

   lp_width_a: assert property (s.en && $fell(PANEL.line_pulse) |->
      lp_hi == 16'(9 * TS_CYC)) else $error("line pulse width wrong");
   fp_setup_a: assert property (s.en && $rose(PANEL.frame_pulse) |->
      !PANEL.line_pulse && lp_lo == 16'(9 * TS_CYC)) else $error("frame pulse rose off place");
   fp_hold_a: assert property (s.en && $fell(PANEL.frame_pulse) |->
      lp_lo == 16'(9 * TS_CYC)) else $error("frame pulse hold wrong");
   ac_delay_a: assert property (s.en && $changed(PANEL.ac_bias_toggle) |->
      PANEL.line_pulse && lp_hi == 16'(TS_CYC)) else $error("ac bias moved off place");
   shift_first_a: assert property ($rose(PANEL.shift) |->
      !PANEL.line_pulse && lp_lo >= 16'(23 * TS_CYC)) else $error("shift rose too early");
   shift_half_a: assert property (s.en && $fell(PANEL.shift) |->
      sh_hi == half_cyc(s.mode)) else $error("shift high half wrong");
   shift_idle_a: assert property (s.en && !disp && $past(!disp) |->
      !PANEL.shift && !PANEL.shift2) else $error("shift active in blank");
   // disabling clears the data at any phase, so only an enabled panel is judged
   data_edge_a: assert property (s.en && s.mode != MODE_COLOR8F1 &&
      $changed(PANEL.panel_pixel_data) |-> $rose(PANEL.shift))
      else $error("data moved off shift rise");
   f1_data_a: assert property (s.en && s.mode == MODE_COLOR8F1 &&
      $changed(PANEL.panel_pixel_data) |-> !$changed(PANEL.shift) && !$changed(PANEL.shift2))
      else $error("format 1 data at edge");
   line_period_a: assert property (per_ok && $rose(PANEL.line_pulse) |->
      per == 32'(ht) * 32'(TS_CYC)) else $error("line period wrong");
   frame_line_a: assert property (s.en && $rose(PANEL.frame_pulse) |->
      s.line == vt - 11'h001) else $error("frame pulse on wrong line");

   mono4_c: cover property (s.mode == MODE_MONO4 && $rose(PANEL.frame_pulse));
   mono8_c: cover property (s.mode == MODE_MONO8 && $rose(PANEL.frame_pulse));
   color4_c: cover property (s.mode == MODE_COLOR4 && $fell(PANEL.shift));
   f1_c: cover property (s.mode == MODE_COLOR8F1 && $fell(PANEL.shift2));
endmodule
`default_nettype wire

// >>> passive_lcd_panel_timing_gen_bench.sv
// self-checking bench for the passive lcd panel timing generator
// assumes the constants header and the package are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "panel_timing_defines.svh"
module passive_lcd_panel_timing_gen_bench;
   import panel_timing_pkg::*;
   localparam int DIV = 1;
   localparam int TS = 2 * DIV;
   logic SYS_CLK = 1'b0, RSTN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00, PIX_DATA = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic PREADY, PSLVERR, PIX_REQ, er;
   panel_t PANEL, pp = '0;
   logic on = 1'b0;
   logic [1:0] md = 2'h0;
   logic [6:0] hd = 7'h0;
   logic [4:0] hb = 5'h0;
   logic [9:0] vd = 10'h0;
   logic [5:0] vb = 6'h0;
   logic [7:0] ex, q[$];
   logic [31:0] rv[5] = '{32'h0, 32'h27, 32'h0, 32'hef, 32'h0};
   int n_errors, total_checks, nb, ns, rnd, prnd, i;
   always #5 SYS_CLK = ~SYS_CLK;
   passive_lcd_panel_timing_gen #(.DIV(DIV)) u_passive_lcd_panel_timing_gen (
      .SYS_CLK(SYS_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .PIX_DATA(PIX_DATA), .PIX_REQ(PIX_REQ), .PANEL(PANEL));
   lcd_panel_model #(.TS(TS)) u_lcd_panel_model (
      .clk(SYS_CLK), .on(on), .md(md), .hd(hd), .hb(hb), .vd(vd), .vb(vb),
      .pnl(PANEL), .n_bad(nb), .n_seen(ns));
   // ************
   // tasks
   // ************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", total_checks + ns, n_errors + nb);
      if (n_errors + nb == 0 && total_checks + ns > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge SYS_CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge SYS_CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (n >= 50) chk(32'(n), 32'h0);
   endtask
   task automatic wait_frame;
      int n;
      n = 0;
      while (PANEL.frame_pulse !== 1'b1 && n < 30000) begin
         @(posedge SYS_CLK);
         n++;
      end
      while (PANEL.frame_pulse !== 1'b0 && n < 30000) begin
         @(posedge SYS_CLK);
         n++;
      end
      if (n >= 30000) chk(32'(n), 32'h0);
   endtask
   // ************
   // pixel source and reference queue
   // ************
   always @(posedge SYS_CLK) begin
      if (PIX_REQ === 1'b1) q.push_back(PIX_DATA);
      prnd = $urandom;
      PIX_DATA <= 8'(prnd);
      if (on && ((!PANEL.shift && pp.shift) || (md == 2'h3 && !PANEL.shift2 && pp.shift2))) begin
         if (q.size() == 0) begin
            chk(32'h1, 32'h0);
         end else begin
            ex = q.pop_front();
            if (!md[0]) ex[3:0] = 4'h0;
            chk(32'(PANEL.panel_pixel_data), 32'(ex));
         end
      end
      pp <= PANEL;
   end
   initial begin
      // four modes of at most four 1408-cycle frames each, with margin
      #400_000;
      n_errors++;
      give_verdict();
   end
   initial begin
      rnd = $urandom(32'h9c48);
      repeat (20) @(posedge SYS_CLK);
      RSTN <= 1'b1;
      for (i = 0; i < 5; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk(rd, rv[i]);
      end
      apb(1'b1, 8'h20, 32'hffffffff);
      chk(32'(er), 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0);
      chk(32'(er), 32'h1);
      for (i = 0; i < 4; i++) begin
         rnd = $urandom;
         md = 2'(i);
         hd = 7'(rnd[1:0]);
         hb = 5'(rnd[3:2]);
         // a one-line frame keeps the frame pulse high for good
         vd = 10'(rnd[5:4]) + 10'h001;
         vb = 6'(rnd[7:6]);
         apb(1'b1, `REG_HDISP, 32'(hd));
         apb(1'b1, `REG_HBLANK, 32'(hb));
         apb(1'b1, `REG_VDISP, 32'(vd));
         apb(1'b1, `REG_VBLANK, 32'(vb));
         apb(1'b0, `REG_HDISP, 32'h0);
         chk(rd, 32'(hd));
         apb(1'b0, `REG_VDISP, 32'h0);
         chk(rd, 32'(vd));
         q.delete();
         on <= 1'b1;
         apb(1'b1, `REG_CTRL, {29'h0, md, 1'b1});
         repeat (2) wait_frame();
         // third frame start: bias toggled odd times, line 0 shown
         apb(1'b0, `REG_STATUS, 32'h0);
         chk(rd, 32'h00020000);
         wait_frame();
         on <= 1'b0;
         apb(1'b1, `REG_CTRL, {29'h0, md, 1'b0});
         repeat (8) @(posedge SYS_CLK);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
